// ---- cfm_defines.vh ----
// constants for the pcm clock fault monitor
`ifndef CFM_DEFINES_VH
`define CFM_DEFINES_VH

// ==========================================================
// register offsets
`define CFM_ADDR_FAULT_MASK    8'h02
`define CFM_ADDR_FAULT_STATUS  8'h03

// ==========================================================
// field positions
`define CFM_BIT_LOCK_FAULT     7
`define CFM_BIT_FRAME_FAULT    6
`define CFM_BIT_BITCLK_FAULT   5
`define CFM_BIT_SRAM_DONE      4
`define CFM_BIT_PLL_LOCKED     3
`define CFM_BIT_RATIO_OK       2
`define CFM_BIT_FRAME_VALID    1
`define CFM_BIT_BITCLK_VALID   0
`define CFM_FAULT_LSB          5

// ==========================================================
// reset values
`define CFM_MASK_RESET         3'h0
`define CFM_FLAG_RESET         3'h0

// ==========================================================
// timing
`define CFM_REF_CLK_MHZ        20
`define CFM_BITCLK_MIN_KHZ     128
`define CFM_BITCLK_MAX_CYC     ((`CFM_REF_CLK_MHZ * 1000) / `CFM_BITCLK_MIN_KHZ)
`define CFM_FS_TIMEOUT_NS      250000
`define CFM_FS_TIMEOUT_CYC     ((`CFM_FS_TIMEOUT_NS * `CFM_REF_CLK_MHZ) / 1000)
`define CFM_RATIO_MIN          16'h0010
`define CFM_LOCK_FRAMES        2'h2
`define CFM_SRAM_CLEAR_CYC     64

`endif

// ---- cfm_monitor_chk.sv ----
// port checker for the pcm clock fault monitor
`timescale 1ns/1ps
// ==========
// assertions
module cfm_monitor_chk #(
	parameter integer FS_TIMEOUT_CYC = 5000
) (
	input wire       i_ref_clk,
	input wire       i_rst,
	input wire [7:0] i_reg_addr,
	input wire       i_reg_wr,
	input wire       i_reg_rd,
	input wire [7:0] i_reg_wdata,
	input wire [7:0] o_reg_rdata,
	input wire       o_reg_rvalid,
	input wire       o_irq
);
	reg  [2:0] msk;
	reg  [6:0] age;
	wire       rd3;
	assign rd3 = i_reg_rd && i_reg_addr == 8'h03;
	// shadow of the mask so reads and the interrupt can be judged
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			msk <= 3'h0;
			age <= 7'h00;
		end else begin
			if (i_reg_wr && i_reg_addr == 8'h02)
				msk <= i_reg_wdata[7:5];
			if (age != 7'h7F)
				age <= age + 7'h01;
		end
	end
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	sequence s_answer;
		##1 o_reg_rvalid;
	endsequence
	a_read_answer: assert property (i_reg_rd |-> s_answer)
		else $error("read not answered");
	a_rvalid_cause: assert property (o_reg_rvalid |-> $past(i_reg_rd))
		else $error("answer without read");
	a_rdata_hold: assert property (!$past(i_reg_rd) |-> $stable(o_reg_rdata))
		else $error("read data moved");
	a_unmapped_zero: assert property (i_reg_rd && i_reg_addr[7:1] != 7'h01 |=> o_reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_mask_read: assert property (i_reg_rd && i_reg_addr == 8'h02 |=> o_reg_rdata == {$past(msk), 5'h00})
		else $error("mask readback wrong");
	a_irq_masked: assert property ((msk == 3'h7) [*3] |-> !o_irq)
		else $error("masked interrupt raised");
	a_sram_busy: assert property (rd3 && age < 7'h3C |=> !o_reg_rdata[4])
		else $error("sram done too early");
	a_sram_done: assert property (rd3 && age > 7'h64 |=> o_reg_rdata[4])
		else $error("sram done missing");
endmodule

bind cfm_pcm_clock_fault_monitor cfm_monitor_chk #(.FS_TIMEOUT_CYC(FS_TIMEOUT_CYC)) u_chk (
	.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
	.i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
	.o_reg_rvalid(o_reg_rvalid), .o_irq(o_irq));

// ---- cfm_pcm_clock_fault_monitor.v ----
// pcm clock fault monitor: clock checks, sticky faults, mask and status registers
`timescale 1ns/1ps
`include "cfm_defines.vh"


module cfm_pcm_clock_fault_monitor #(
	parameter integer FS_TIMEOUT_CYC = `CFM_FS_TIMEOUT_CYC
) (
	input  wire       i_ref_clk,
	input  wire       i_rst,
	input  wire       i_bit_clk,
	input  wire       i_frame_sync,
	input  wire [7:0] i_reg_addr,
	input  wire       i_reg_wr,
	input  wire       i_reg_rd,
	input  wire [7:0] i_reg_wdata,
	output reg  [7:0] o_reg_rdata,
	output reg        o_reg_rvalid,
	output reg        o_irq
);

	localparam integer BCLK_MAX_I = `CFM_BITCLK_MAX_CYC;
	localparam integer SRAM_CYC_I = `CFM_SRAM_CLEAR_CYC;

	// sram clear states
	localparam [1:0] ST_IDLE  = 2'h0;
	localparam [1:0] ST_CLEAR = 2'h1;
	localparam [1:0] ST_DONE  = 2'h2;

	function is_addr;
		input [7:0] addr;
		input [7:0] target;
		begin
			is_addr = (addr == target);
		end
	endfunction

	// ==========================================================
	// pin synchronisers
	// a change is taken only when stages two and three agree, which
	// rejects a single sampled glitch on the pins
	reg  [2:0] bclk_sync;
	reg  [2:0] fs_sync;
	reg        bclk_filt;
	reg        fs_filt;
	wire       bclk_rise;
	wire       fs_rise;

	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			bclk_sync <= 3'h0;
			fs_sync   <= 3'h0;
			bclk_filt <= 1'b0;
			fs_filt   <= 1'b0;
		end else begin
			bclk_sync <= {bclk_sync[1:0], i_bit_clk};
			fs_sync   <= {fs_sync[1:0], i_frame_sync};
			if (bclk_sync[1] == bclk_sync[2]) begin
				bclk_filt <= bclk_sync[2];
			end
			if (fs_sync[1] == fs_sync[2]) begin
				fs_filt <= fs_sync[2];
			end
		end
	end

	assign bclk_rise = (bclk_sync[1] == bclk_sync[2]) & bclk_sync[2] & ~bclk_filt;
	assign fs_rise   = (fs_sync[1] == fs_sync[2]) & fs_sync[2] & ~fs_filt;

	// ==========================================================
	// bit clock rate check
	reg  [7:0] bclk_gap;
	reg        bitclk_valid;

	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			bclk_gap     <= 8'h00;
			bitclk_valid <= 1'b0;
		end else if (bclk_rise) begin
			bclk_gap     <= 8'h00;
			bitclk_valid <= (bclk_gap < BCLK_MAX_I[7:0]);
		end else if (bclk_gap >= BCLK_MAX_I[7:0]) begin
			// no edge within one period of the slowest legal rate
			bitclk_valid <= 1'b0;
		end else begin
			bclk_gap <= bclk_gap + 8'h01;
		end
	end

	// ==========================================================
	// frame sync presence, ratio and lock
	reg  [15:0] fs_gap;
	reg         frame_sync_valid;
	reg  [15:0] edge_cnt;
	reg  [15:0] last_cnt;
	reg         frame_ratio_ok;
	reg  [1:0]  lock_cnt;
	reg         pll_locked;
	wire        good_frame;

	assign good_frame = (edge_cnt >= `CFM_RATIO_MIN) & (edge_cnt == last_cnt) & frame_sync_valid;

	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			fs_gap           <= 16'h0000;
			frame_sync_valid <= 1'b0;
		end else if (fs_rise) begin
			fs_gap           <= 16'h0000;
			frame_sync_valid <= (fs_gap < FS_TIMEOUT_CYC[15:0]);
		end else if (fs_gap >= FS_TIMEOUT_CYC[15:0]) begin
			frame_sync_valid <= 1'b0;
		end else begin
			fs_gap <= fs_gap + 16'h0001;
		end
	end

	// the ratio counts bit clock edges per frame; it is good only while
	// two frames in a row agree, so a drifting clock is caught at once
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			edge_cnt       <= 16'h0000;
			last_cnt       <= 16'h0000;
			frame_ratio_ok <= 1'b0;
			lock_cnt       <= 2'h0;
			pll_locked     <= 1'b0;
		end else if (!frame_sync_valid && !fs_rise) begin
			edge_cnt       <= 16'h0000;
			last_cnt       <= 16'h0000;
			frame_ratio_ok <= 1'b0;
			lock_cnt       <= 2'h0;
			pll_locked     <= 1'b0;
		end else if (fs_rise) begin
			edge_cnt       <= {15'h0000, bclk_rise};
			last_cnt       <= edge_cnt;
			frame_ratio_ok <= good_frame;
			if (!good_frame) begin
				lock_cnt   <= 2'h0;
				pll_locked <= 1'b0;
			end else if (lock_cnt == `CFM_LOCK_FRAMES) begin
				pll_locked <= 1'b1;
			end else begin
				lock_cnt <= lock_cnt + 2'h1;
			end
		end else if (bclk_rise && edge_cnt != 16'hFFFF) begin
			edge_cnt <= edge_cnt + 16'h0001;
		end
	end

	// ==========================================================
	// sram clear after reset
	reg  [1:0] sram_state;
	reg  [6:0] sram_cnt;
	reg        sram_clear_done;

	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			sram_state      <= ST_IDLE;
			sram_cnt        <= 7'h00;
			sram_clear_done <= 1'b0;
		end else begin
			case (sram_state)
				ST_IDLE: begin
					sram_state <= ST_CLEAR;
				end
				ST_CLEAR: begin
					if (sram_cnt == SRAM_CYC_I[6:0] - 7'h01) begin
						sram_state      <= ST_DONE;
						sram_clear_done <= 1'b1;
					end else begin
						sram_cnt <= sram_cnt + 7'h01;
					end
				end
				ST_DONE: begin
					sram_clear_done <= 1'b1;
				end
				default: begin
					sram_state      <= ST_IDLE;
					sram_clear_done <= 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// sticky fault flags, index 0 bit clock, 1 frame, 2 lock
	reg  [2:0] watch_prev;
	reg  [2:0] fault_flag;
	reg  [2:0] fault_mask;
	wire [2:0] watch_now;
	wire [2:0] fault_set;
	wire       status_wr;
	wire       mask_wr;

	assign watch_now = {pll_locked, frame_sync_valid & frame_ratio_ok, bitclk_valid};
	assign status_wr = i_reg_wr & is_addr(i_reg_addr, `CFM_ADDR_FAULT_STATUS);
	assign mask_wr   = i_reg_wr & is_addr(i_reg_addr, `CFM_ADDR_FAULT_MASK);

	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			watch_prev <= 3'h0;
		end else begin
			watch_prev <= watch_now;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : gen_fault
			// falling indication; for the frame fault either input falling counts
			assign fault_set[g] = watch_prev[g] & ~watch_now[g];

			// a fault arriving in the clearing cycle wins over the clear
			always @(posedge i_ref_clk) begin
				if (i_rst) begin
					fault_flag[g] <= 1'b0;
				end else if (fault_set[g]) begin
					fault_flag[g] <= 1'b1;
				end else if (status_wr && i_reg_wdata[`CFM_FAULT_LSB + g]) begin
					fault_flag[g] <= 1'b0;
				end
			end
		end
	endgenerate

	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			fault_mask <= `CFM_MASK_RESET;
		end else if (mask_wr) begin
			fault_mask <= i_reg_wdata[`CFM_BIT_LOCK_FAULT:`CFM_FAULT_LSB];
		end
	end

	// ==========================================================
	// interrupt request, one cycle behind the flags
	// taken from a flip-flop so the pin never glitches while a flag and its mask change
	wire [2:0] irq_pending;

	assign irq_pending = fault_flag & ~fault_mask;

	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |irq_pending;
		end
	end

	// ==========================================================
	// register words, each bit placed by its field position so that a
	// moved field only needs the defines changed
	wire [7:0] mask_word;
	wire [7:0] status_word;

	assign mask_word[`CFM_BIT_LOCK_FAULT:`CFM_FAULT_LSB] = fault_mask;
	assign mask_word[`CFM_FAULT_LSB - 1:0]              = 5'h00;
	assign status_word[`CFM_BIT_LOCK_FAULT]   = fault_flag[2];
	assign status_word[`CFM_BIT_FRAME_FAULT]  = fault_flag[1];
	assign status_word[`CFM_BIT_BITCLK_FAULT] = fault_flag[0];
	assign status_word[`CFM_BIT_SRAM_DONE]    = sram_clear_done;
	assign status_word[`CFM_BIT_PLL_LOCKED]   = pll_locked;
	assign status_word[`CFM_BIT_RATIO_OK]     = frame_ratio_ok;
	assign status_word[`CFM_BIT_FRAME_VALID]  = frame_sync_valid;
	assign status_word[`CFM_BIT_BITCLK_VALID] = bitclk_valid;

	// ==========================================================
	// register read port, data one cycle after the strobe
	reg  [7:0] next_rdata;

	always @* begin
		next_rdata = 8'h00;
		if (is_addr(i_reg_addr, `CFM_ADDR_FAULT_MASK)) begin
			next_rdata = mask_word;
		end else if (is_addr(i_reg_addr, `CFM_ADDR_FAULT_STATUS)) begin
			next_rdata = status_word;
		end
	end

	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_reg_rdata  <= 8'h00;
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rvalid <= i_reg_rd;
			if (i_reg_rd) begin
				o_reg_rdata <= next_rdata;
			end
		end
	end

endmodule

// ---- cfm_pcm_host.sv ----
// pcm host model making the bit clock and frame sync
`timescale 1ns/1ps
// ==========
// host clock source
module cfm_pcm_host (
	input  wire       i_run_clk,
	input  wire       i_run_fs,
	input  wire [7:0] i_bits,
	output reg        o_bit_clk,
	output reg        o_frame_sync
);
	reg [7:0] n;
	// a stopped host parks both lines low instead of freezing mid frame
	initial begin
		o_bit_clk = 1'b0;
		o_frame_sync = 1'b0;
		n = 8'h00;
		forever begin
			#200;
			if (i_run_clk) begin
				o_bit_clk = ~o_bit_clk;
				if (!o_bit_clk) begin
					n = (n + 8'h01 >= i_bits) ? 8'h00 : n + 8'h01;
					o_frame_sync = i_run_fs && n == 8'h00;
				end
			end else begin
				o_bit_clk = 1'b0;
				o_frame_sync = 1'b0;
			end
		end
	end
endmodule

// ---- tb_pcm_clock_fault_monitor.sv ----
// testbench for the pcm clock fault monitor
`timescale 1ns/1ps
// ==========
// stimulus and checks
module tb_pcm_clock_fault_monitor;
	reg         clk;
	reg         rst;
	reg  [7:0]  addr;
	reg         wr;
	reg         rd;
	reg  [7:0]  wdata;
	reg         run_clk;
	reg  [7:0]  bits;
	reg  [15:0] rnd;
	wire        bclk;
	wire        fs;
	wire [7:0]  rdata;
	wire        rvalid;
	wire        irq;
	integer     fails;
	integer     compares;
	integer     i;
	cfm_pcm_clock_fault_monitor #(.FS_TIMEOUT_CYC(400)) dut_u (
		.i_ref_clk(clk), .i_rst(rst), .i_bit_clk(bclk), .i_frame_sync(fs),
		.i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
		.o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_irq(irq));
	cfm_pcm_host host_u (.i_run_clk(run_clk), .i_run_fs(1'b1), .i_bits(bits),
		.o_bit_clk(bclk), .o_frame_sync(fs));
	function [15:0] lfsr(input [15:0] x);
		lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	function [7:0] st(input [2:0] f, input [3:0] live);
		st = {f, 1'b1, live};
	endfunction
	task chk(input [7:0] g, input [7:0] e);
		begin
			compares = compares + 1;
			if (g !== e) begin
				fails = fails + 1;
				$display("wrong value at %0t: got %h expected %h", $time, g, e);
			end
		end
	endtask
	task wreg(input [7:0] a, input [7:0] d);
		begin
			@(posedge clk);
			addr <= a;
			wdata <= d;
			wr <= 1'b1;
			@(posedge clk);
			wr <= 1'b0;
		end
	endtask
	task rreg(input [7:0] a, input [7:0] e);
		begin
			@(posedge clk);
			addr <= a;
			rd <= 1'b1;
			@(posedge clk);
			rd <= 1'b0;
			#1;
			chk({7'h00, rvalid}, 8'h01);
			chk(rdata, e);
		end
	endtask
	task irqchk(input e);
		begin
			repeat (3) @(posedge clk);
			#1;
			chk({7'h00, irq}, {7'h00, e});
		end
	endtask
	task end_of_test;
		begin
			$display("compares %0d fails %0d", compares, fails);
			if (fails == 0 && compares > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// the whole sequence needs under 8000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		fails = fails + 1;
		end_of_test;
	end
	initial begin
		{rst, addr, wr, rd, wdata, run_clk} = {1'b1, 19'h00000};
		bits = 8'h20;
		fails = 0;
		compares = 0;
		rnd = 16'hB3DD;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rreg(8'h03, 8'h00);
		rreg(8'h02, 8'h00);
		run_clk <= 1'b1;
		repeat (2000) @(posedge clk);
		rreg(8'h03, st(3'h0, 4'hF));
		irqchk(1'b0);
		for (i = 0; i < 6; i = i + 1) begin
			rnd = lfsr(rnd);
			wreg(8'h02, rnd[7:0]);
			rreg(8'h02, rnd[7:0] & 8'hE0);
			rreg({1'b1, rnd[14:8]}, 8'h00);
		end
		wreg(8'h02, 8'h00);
		wreg(8'h85, 8'hFF);
		rreg(8'h02, 8'h00);
		$display("end registers");
		bits <= 8'h14;
		repeat (2000) @(posedge clk);
		rreg(8'h03, st(3'h6, 4'hF));
		irqchk(1'b1);
		wreg(8'h03, 8'h40);
		rreg(8'h03, st(3'h4, 4'hF));
		wreg(8'h02, 8'h80);
		irqchk(1'b0);
		wreg(8'h03, 8'h80);
		wreg(8'h02, 8'h00);
		irqchk(1'b0);
		$display("end ratio");
		run_clk <= 1'b0;
		repeat (1000) @(posedge clk);
		rreg(8'h03, st(3'h7, 4'h0));
		for (i = 0; i < 8; i = i + 1) begin
			wreg(8'h02, {i[2:0], 5'h00});
			irqchk(i != 7);
		end
		wreg(8'h02, 8'h00);
		run_clk <= 1'b1;
		repeat (2000) @(posedge clk);
		rreg(8'h03, st(3'h7, 4'hF));
		wreg(8'h03, 8'hE0);
		rreg(8'h03, st(3'h0, 4'hF));
		irqchk(1'b0);
		$display("end clock loss");
		end_of_test;
	end
endmodule
